// ==== rtl/pia_regs.sv ====
`timescale 1ns/1ps
module pia_regs
  import pia_pkg::*;
(
  // clock and reset
  input  wire logic       clk,
  input  wire logic       rst_b,
  // management port pins
  input  wire logic       mdc,
  input  wire logic       mdio_in,
  output logic            mdio_out,
  output logic            mdio_oe,
  // station address straps
  input  wire logic [4:0] phy_addr,
  // negotiation engine
  input  wire logic       word_recognized,
  output pia_adv_t        base_page
);

  logic       mdc_s1, mdc_s2, mdc_s3, mdio_s1, mdio_s2;
  logic [4:0] addr_s1, addr_s2;

  // two-stage synchronisers for pins
  always_ff @(posedge clk) begin
    mdc_s1  <= mdc;
    mdc_s2  <= mdc_s1;
    mdc_s3  <= mdc_s2;
    mdio_s1 <= mdio_in;
    mdio_s2 <= mdio_s1;
    addr_s1 <= phy_addr;
    addr_s2 <= addr_s1;
  end

  logic mdc_rise;
  logic bit_in;
  assign mdc_rise = mdc_s2 & ~mdc_s3;
  assign bit_in   = mdio_s2;

  pia_state_t  state, next_state;
  logic [5:0]  cnt, next_cnt;
  logic [15:0] shreg, next_shreg;
  logic        is_rd, next_is_rd;
  logic        hit, next_hit;
  logic        drv, next_drv;
  logic [4:0]  regad, next_regad;
  logic        next_mdio_out, next_mdio_oe;
  pia_adv_t    adv, next_adv;
  pia_adv_t    next_base_page;
  logic        wr_stb;
  logic [15:0] shifted;
  logic [15:0] rd_word;

  assign shifted = {shreg[14:0], bit_in};

  function automatic logic owned(input logic [4:0] a);
    return (a == PIA_ADDR_ID_HIGH) || (a == PIA_ADDR_ID_LOW) || (a == PIA_ADDR_ADVERT);
  endfunction

  // read value for the address just shifted in
  always_comb begin
    unique case (shifted[4:0])
      PIA_ADDR_ID_HIGH: rd_word = PIA_OUI_3_24[21:6];
      PIA_ADDR_ID_LOW:  rd_word = {PIA_OUI_3_24[5:0], PIA_PART_NUM, PIA_REV_NUM};
      PIA_ADDR_ADVERT:  rd_word = adv;
      default:          rd_word = 16'h0000;
    endcase
  end

  // frame sequencer
  always_comb begin
    next_state    = state;
    next_cnt      = cnt;
    next_shreg    = shreg;
    next_is_rd    = is_rd;
    next_hit      = hit;
    next_drv      = drv;
    next_regad    = regad;
    next_mdio_out = mdio_out;
    next_mdio_oe  = mdio_oe;
    wr_stb        = 1'b0;
    if (mdc_rise) begin
      unique case (state)
        PIA_ST_PRE: begin
          if (bit_in) begin
            next_cnt = (cnt == PIA_PRE_LEN) ? cnt : cnt + 6'h01;
          end else begin
            next_cnt = 6'h00;
            if (cnt == PIA_PRE_LEN) next_state = PIA_ST_START;
          end
        end
        PIA_ST_START: begin
          next_cnt   = 6'h00;
          next_state = bit_in ? PIA_ST_OP : PIA_ST_PRE;
        end
        PIA_ST_OP: begin
          next_shreg = shifted;
          next_cnt   = cnt + 6'h01;
          if (cnt == 6'h01) begin
            next_cnt   = 6'h00;
            next_is_rd = (shifted[1:0] == PIA_OP_READ);
            if ((shifted[1:0] == PIA_OP_READ) || (shifted[1:0] == PIA_OP_WRITE)) begin
              next_state = PIA_ST_PHY;
            end else begin
              next_state = PIA_ST_PRE;
            end
          end
        end
        PIA_ST_PHY: begin
          next_shreg = shifted;
          next_cnt   = cnt + 6'h01;
          if (cnt == PIA_FIELD_LAST) begin
            next_cnt   = 6'h00;
            next_hit   = (shifted[4:0] == addr_s2);
            next_state = PIA_ST_REG;
          end
        end
        PIA_ST_REG: begin
          next_shreg = shifted;
          next_cnt   = cnt + 6'h01;
          if (cnt == PIA_FIELD_LAST) begin
            next_cnt   = 6'h00;
            next_regad = shifted[4:0];
            next_drv   = is_rd & hit & owned(shifted[4:0]);
            next_shreg = rd_word;
            next_state = PIA_ST_TA;
          end
        end
        PIA_ST_TA: begin
          next_cnt = cnt + 6'h01;
          if (cnt == 6'h00) begin
            next_mdio_oe  = drv;
            next_mdio_out = 1'b0;
          end else begin
            next_cnt   = 6'h00;
            next_state = PIA_ST_DATA;
            if (drv) begin
              next_mdio_out = shreg[15];
              next_shreg    = {shreg[14:0], 1'b0};
            end
          end
        end
        PIA_ST_DATA: begin
          next_cnt = cnt + 6'h01;
          if (drv) begin
            next_mdio_out = shreg[15];
            next_shreg    = {shreg[14:0], 1'b0};
          end else begin
            next_shreg = shifted;
          end
          if (cnt == PIA_DATA_LAST) begin
            next_cnt      = 6'h00;
            next_state    = PIA_ST_PRE;
            next_mdio_oe  = 1'b0;
            next_mdio_out = 1'b0;
            next_drv      = 1'b0;
            wr_stb        = ~is_rd & hit & (regad == PIA_ADDR_ADVERT);
          end
        end
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      state    <= PIA_ST_PRE;
      cnt      <= 6'h00;
      shreg    <= 16'h0000;
      is_rd    <= 1'b0;
      hit      <= 1'b0;
      drv      <= 1'b0;
      regad    <= 5'h00;
      mdio_out <= 1'b0;
      mdio_oe  <= 1'b0;
    end else begin
      state    <= next_state;
      cnt      <= next_cnt;
      shreg    <= next_shreg;
      is_rd    <= next_is_rd;
      hit      <= next_hit;
      drv      <= next_drv;
      regad    <= next_regad;
      mdio_out <= next_mdio_out;
      mdio_oe  <= next_mdio_oe;
    end
  end

  // advertisement register and sent base page
  always_comb begin
    next_adv                = adv;
    next_adv.ack            = word_recognized;
    if (wr_stb) begin
      next_adv.remote_fault_flag        = shifted[13];
      next_adv.four_pair_ability        = shifted[9];
      next_adv.fast_full_duplex_ability = shifted[8];
      next_adv.fast_half_duplex_ability = shifted[7];
      next_adv.ten_full_duplex_ability  = shifted[6];
      next_adv.ten_half_duplex_ability  = shifted[5];
      next_adv.selector                 = shifted[0];
    end
    next_adv.next_page_flag = 1'b0;
    next_adv.rsvd_hi        = 3'h0;
    next_adv.rsvd_lo        = 4'h0;
    next_base_page          = adv;
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      adv       <= pia_adv_t'(PIA_ADV_RESET);
      base_page <= pia_adv_t'(PIA_ADV_RESET);
    end else begin
      adv       <= next_adv;
      base_page <= next_base_page;
    end
  end

  property p_reset_value;
    @(posedge clk) $rose(rst_b) |-> (adv == pia_adv_t'(PIA_ADV_RESET));
  endproperty
  a_reset_value: assert property (p_reset_value) else $error("advert reset value wrong");

  property p_np_zero;
    @(posedge clk) disable iff (!rst_b) !base_page.next_page_flag && !adv.next_page_flag;
  endproperty
  a_np_zero: assert property (p_np_zero) else $error("next page bit set");

  property p_ack_follow;
    @(posedge clk) disable iff (!rst_b) $rose(word_recognized) ##2 1'b1 |-> base_page.ack;
  endproperty
  a_ack_follow: assert property (p_ack_follow) else $error("ack not shown in base page");

  property p_id_high;
    @(posedge clk) disable iff (!rst_b) (shifted[4:0] == PIA_ADDR_ID_HIGH) |-> (rd_word == 16'(PIA_OUI_3_24 >> 6));
  endproperty
  a_id_high: assert property (p_id_high) else $error("id high wrong");

  property p_id_low;
    @(posedge clk) disable iff (!rst_b) (shifted[4:0] == PIA_ADDR_ID_LOW) |->
      (rd_word[15:10] == PIA_OUI_3_24[5:0]) && (rd_word[9:4] == PIA_PART_NUM) && (rd_word[3:0] == PIA_REV_NUM);
  endproperty
  a_id_low: assert property (p_id_low) else $error("id low wrong");

  property p_write_bits;
    @(posedge clk) disable iff (!rst_b) wr_stb |=>
      (adv.remote_fault_flag == $past(shifted[13])) && (adv.four_pair_ability == $past(shifted[9])) &&
      (adv.fast_full_duplex_ability == $past(shifted[8])) && (adv.fast_half_duplex_ability == $past(shifted[7])) &&
      (adv.ten_full_duplex_ability == $past(shifted[6])) && (adv.ten_half_duplex_ability == $past(shifted[5])) &&
      (adv.selector == $past(shifted[0]));
  endproperty
  a_write_bits: assert property (p_write_bits) else $error("advert write lost");

  // written bits must reach the sent word two clocks after the strobe
  property p_base_page;
    @(posedge clk) disable iff (!rst_b) wr_stb ##2 1'b1 |-> (base_page == $past(adv)) &&
      (base_page.remote_fault_flag == $past(shifted[13], 2)) &&
      (base_page.four_pair_ability == $past(shifted[9], 2)) &&
      (base_page.selector == $past(shifted[0], 2));
  endproperty
  a_base_page: assert property (p_base_page) else $error("base page stale");

  property p_oe_window;
    @(posedge clk) disable iff (!rst_b) $rose(mdio_oe) |-> is_rd && hit && (state == PIA_ST_TA) && !mdio_out;
  endproperty
  a_oe_window: assert property (p_oe_window) else $error("mdio driven outside read turnaround");

endmodule

// ==== rtl/pia_pkg.sv ====
// Contract
// - id high: identifier bits 3..18, read-only
// - id low 15:10: identifier bits 19..24
// - id low 9:4: fixed part number
// - id low 3:0: fixed revision code
// - advertisement resets to 0x01e1
// - next page bit reads zero always
// - acknowledge bit follows word recognition, reset 0
// - remote fault bit writable, resets 0
// - four-pair ability bit 9 writable, reset 0
// - fast full duplex bit 8, reset 1
// - fast half duplex bit 7, reset 1
// - ten full duplex bit 6, reset 1
// - ten half duplex bit 5, reset 1
// - selector bit 0 writable, reset 1
package pia_pkg;

  // register addresses on the management port
  localparam logic [4:0]  PIA_ADDR_ID_HIGH = 5'h02;
  localparam logic [4:0]  PIA_ADDR_ID_LOW  = 5'h03;
  localparam logic [4:0]  PIA_ADDR_ADVERT  = 5'h04;

  // identity values, arbitrary; msb of the oui field is identifier bit 3
  localparam logic [21:0] PIA_OUI_3_24     = 22'h2d5a71;
  localparam logic [5:0]  PIA_PART_NUM     = 6'h2b;
  localparam logic [3:0]  PIA_REV_NUM      = 4'h3;

  localparam logic [15:0] PIA_ADV_RESET    = 16'h01e1;

  // management frame
  localparam logic [5:0]  PIA_PRE_LEN      = 6'h20;
  localparam logic [1:0]  PIA_OP_READ      = 2'h2;
  localparam logic [1:0]  PIA_OP_WRITE     = 2'h1;
  localparam logic [5:0]  PIA_FIELD_LAST   = 6'h04;
  localparam logic [5:0]  PIA_DATA_LAST    = 6'h0f;

  typedef struct packed {
    logic       next_page_flag;
    logic       ack;
    logic       remote_fault_flag;
    logic [2:0] rsvd_hi;
    logic       four_pair_ability;
    logic       fast_full_duplex_ability;
    logic       fast_half_duplex_ability;
    logic       ten_full_duplex_ability;
    logic       ten_half_duplex_ability;
    logic [3:0] rsvd_lo;
    logic       selector;
  } pia_adv_t;

  typedef enum logic [2:0] {
    PIA_ST_PRE,
    PIA_ST_START,
    PIA_ST_OP,
    PIA_ST_PHY,
    PIA_ST_REG,
    PIA_ST_TA,
    PIA_ST_DATA
  } pia_state_t;

endpackage

// ==== verif/pia_mgmt_model.sv ====
`timescale 1ns/1ps
module pia_mgmt_model
  import pia_pkg::*;
(
  // device clock
  input  wire logic clk,
  // management pins
  input  wire logic mdio_out,
  input  wire logic mdio_oe,
  output logic      mdc,
  output logic      mdio_in
);
  logic drv;
  logic drv_en;

  // pull-up holds the line high when nobody drives
  assign mdio_in = mdio_oe ? mdio_out : (drv_en ? drv : 1'b1);

  initial begin
    mdc    = 1'b0;
    drv    = 1'b1;
    drv_en = 1'b0;
  end

  task automatic wait_clk(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  // one mdc period; sample just before the rising edge
  task automatic bit_cyc(input logic en, input logic b, output logic s);
    mdc    = 1'b0;
    drv_en = en;
    drv    = b;
    wait_clk(6);
    s   = mdio_in;
    mdc = 1'b1;
    wait_clk(6);
  endtask

  task automatic frame(input logic [1:0] op, input logic [4:0] pa, input logic [4:0] ra,
                       input logic [15:0] wd, output logic [15:0] rd);
    logic [13:0] hdr;
    logic [17:0] tail;
    logic        s;
    hdr  = {2'b01, op, pa, ra};
    tail = {2'b10, wd & ~16'h1c1e};
    for (int i = 0; i < 32; i++) begin
      bit_cyc(1'b1, 1'b1, s);
    end
    for (int i = 13; i >= 0; i--) begin
      bit_cyc(1'b1, hdr[i], s);
    end
    // read: line released through turnaround and data
    for (int i = 17; i >= 0; i--) begin
      bit_cyc(op == PIA_OP_WRITE, tail[i], s);
      if (i < 16) begin
        rd[i] = s;
      end
    end
    mdc    = 1'b0;
    drv_en = 1'b0;
    wait_clk(8);
  endtask
endmodule

// ==== verif/pia_regs_bench.sv ====
`timescale 1ns/1ps
module pia_regs_bench
  import pia_pkg::*;
;
  localparam logic [4:0] MY_ADDR = 5'h05;

  logic        clk;
  logic        rst_b;
  logic        mdc;
  logic        mdio_in;
  logic        mdio_out;
  logic        mdio_oe;
  logic        word_recognized;
  logic [4:0]  phy_addr;
  pia_adv_t    base_page;
  logic [15:0] rdata;
  int          fails;
  int          checks;
  int          cycles;

  always #5 clk = ~clk;

  pia_regs DUT (.clk(clk), .rst_b(rst_b), .mdc(mdc), .mdio_in(mdio_in), .mdio_out(mdio_out),
                .mdio_oe(mdio_oe), .phy_addr(phy_addr), .word_recognized(word_recognized),
                .base_page(base_page));

  pia_mgmt_model m (.clk(clk), .mdio_out(mdio_out), .mdio_oe(mdio_oe), .mdc(mdc), .mdio_in(mdio_in));

  task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
    checks++;
    if (got !== exp) begin
      fails++;
      $display("wrong value %s expected %h seen %h", nm, exp, got);
    end
  endtask

  task automatic end_of_test;
    $display("checks %0d fails %0d", checks, fails);
    if (fails == 0 && checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  task automatic rd(input logic [4:0] ra);
    m.frame(PIA_OP_READ, MY_ADDR, ra, 16'h0000, rdata);
  endtask

  task automatic wr(input logic [4:0] ra, input logic [15:0] d);
    m.frame(PIA_OP_WRITE, MY_ADDR, ra, d, rdata);
  endtask

  task automatic adv_rt(input logic [15:0] wd, input logic [15:0] exp);
    wr(PIA_ADDR_ADVERT, wd);
    chk("base page", exp, base_page);
    rd(PIA_ADDR_ADVERT);
    chk("advert read", exp, rdata);
  endtask

  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      fails++;
      end_of_test;
    end
  end

  initial begin
    clk             = 1'b0;
    rst_b           = 1'b0;
    phy_addr        = MY_ADDR;
    word_recognized = 1'b0;
    fails           = 0;
    checks          = 0;
    cycles          = 0;
    m.wait_clk(4);
    rst_b = 1'b1;
    chk("base page reset", PIA_ADV_RESET, base_page);
    rd(PIA_ADDR_ADVERT);
    chk("advert reset", 16'h01e1, rdata);
    rd(PIA_ADDR_ID_HIGH);
    chk("id high", PIA_OUI_3_24[21:6], rdata);
    wr(PIA_ADDR_ID_HIGH, ~PIA_OUI_3_24[21:6]);
    rd(PIA_ADDR_ID_HIGH);
    chk("id high kept", PIA_OUI_3_24[21:6], rdata);
    wr(PIA_ADDR_ID_LOW, 16'h0000);
    rd(PIA_ADDR_ID_LOW);
    chk("id low", {PIA_OUI_3_24[5:0], PIA_PART_NUM, PIA_REV_NUM}, rdata);
    $display("test identity done");
    adv_rt(16'he200, 16'h2200);
    adv_rt(16'h81e1, 16'h01e1);
    $display("test advert write done");
    word_recognized = 1'b1;
    m.wait_clk(3);
    chk("base page ack", 16'h41e1, base_page);
    rd(PIA_ADDR_ADVERT);
    chk("advert ack", 16'h41e1, rdata);
    word_recognized = 1'b0;
    rd(PIA_ADDR_ADVERT);
    chk("advert ack gone", 16'h01e1, rdata);
    $display("test acknowledge done");
    m.frame(PIA_OP_READ, ~MY_ADDR, PIA_ADDR_ID_HIGH, 16'h0000, rdata);
    chk("foreign address read", 16'hffff, rdata);
    rd(5'h05);
    chk("unowned register read", 16'hffff, rdata);
    m.frame(2'h0, MY_ADDR, PIA_ADDR_ADVERT, 16'h0000, rdata);
    m.frame(PIA_OP_WRITE, ~MY_ADDR, PIA_ADDR_ADVERT, 16'h0000, rdata);
    rd(PIA_ADDR_ADVERT);
    chk("advert after refused writes", 16'h01e1, rdata);
    wr(PIA_ADDR_ADVERT, 16'h2200);
    rst_b = 1'b0;
    m.wait_clk(4);
    rst_b = 1'b1;
    chk("base page rereset", PIA_ADV_RESET, base_page);
    rd(PIA_ADDR_ADVERT);
    chk("advert rereset", 16'h01e1, rdata);
    $display("test reset again done");
    end_of_test;
  end
endmodule
